/* File: rtl/vtiu_pkg.sv */
package vtiu_pkg;
  // Source count and fixed order positions
  localparam int          NUM_SRC      = 22;
  localparam logic [4:0]  SRC_EXT0     = 5'h00;
  localparam logic [4:0]  SRC_TIMER2   = 5'h05;
  localparam logic [4:0]  SRC_CNT_ARR  = 5'h09;
  localparam logic [4:0]  SRC_CMP0_F   = 5'h0A;
  localparam logic [4:0]  SRC_CMP0_R   = 5'h0B;
  localparam logic [4:0]  SRC_CONV     = 5'h0F;
  localparam logic [4:0]  SRC_UNUSED   = 5'h14;
  localparam logic [4:0]  SRC_XTAL     = 5'h15;
  // Vector layout
  localparam logic [15:0] VEC_RESET    = 16'h0000;
  localparam logic [15:0] VEC_BASE     = 16'h0003;
  localparam logic [15:0] VEC_LAST     = 16'h00AB;
  localparam int          VEC_STEP_LG2 = 3;
  // Peripheral flag bit positions inside their control registers, and the global enable bit of en0
  localparam int          BIT_EXT0_FLG = 1;
  localparam int          BIT_T2_FLG   = 7;
  localparam int          BIT_CA_OVF   = 7;
  localparam int          BIT_CMP_FALL = 4;
  localparam int          BIT_CMP_RISE = 5;
  localparam int          BIT_CONV_FLG = 5;
  localparam int          BIT_GLOBAL   = 7;
  // Register byte addresses
  localparam logic [5:0]  ADDR_EN0     = 6'h00;
  localparam logic [5:0]  ADDR_IE1     = 6'h04;
  localparam logic [5:0]  ADDR_IE2     = 6'h08;
  localparam logic [5:0]  ADDR_IP0     = 6'h0C;
  localparam logic [5:0]  ADDR_IP1     = 6'h10;
  localparam logic [5:0]  ADDR_IP2     = 6'h14;
  localparam logic [5:0]  ADDR_PEND    = 6'h18;
  localparam logic [5:0]  ADDR_SVC     = 6'h1C;
  localparam logic [5:0]  ADDR_STAT    = 6'h20;
  localparam logic [5:0]  ADDR_MASK    = 6'h24;
  // Reset values
  localparam logic [7:0]  RST_ENABLE   = 8'h00;
  localparam logic [7:0]  RST_PRIO     = 8'h00;
  localparam logic [1:0]  RST_EVENT    = 2'h0;
  // Event bits of the status register
  localparam int          EV_GRANT     = 0;
  localparam int          EV_PREEMPT   = 1;
  // Core latency figures, in system clocks
  localparam int          DETECT_CYC   = 1;
  localparam int          CALL_CYC     = 4;
  localparam int          BEST_CYC     = DETECT_CYC + CALL_CYC;
endpackage

/* File: rtl/vtiu_top.sv */
`timescale 1ns/1ps
// Function
// - External interrupt zero: vector 0x0003, order 0
// - Vectors eight bytes apart, up to 0x00AB
// - Timer-2 overflow: vector 0x002B, order 5
// - Counter array: overflow or capture flags, 0x004B
// - Comparator 0 fall/rise sources at 0x0053/0x005B
// - Conversion done: vector 0x007B, order 15
// - Each source low or high priority
// - One priority bit per source
// - High preempts low; high never preempted
// - Priority bits reset to low
// - Higher level wins simultaneous requests
// - Same level: lowest order position wins
// - Flags sampled and decoded every clock
// - Best case: one detect, four call clocks
// - After return, one instruction before call
// - Worst case eighteen clocks
// - Equal or lower waits for return plus one
module vtiu_top
  import vtiu_pkg::*;
#(
  parameter int NUM_CC = 5           // Capture/compare modules
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Avalon-MM slave
  input  wire logic [5:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // Peripheral control registers holding flags, plus direct flag inputs
  input  wire logic [7:0]        timer_ctrl_reg,
  input  wire logic [7:0]        timer2_ctrl_reg,
  input  wire logic [7:0]        counter_array_ctrl_reg,
  input  wire logic [7:0]        comp0_ctrl_reg,
  input  wire logic [7:0]        converter_ctrl_reg,
  input  wire logic              crystal_valid_flag,
  input  wire logic [NUM_SRC-1:0] other_src_flags,
  // Processor core side
  input  wire logic              long_call,
  input  wire logic              return_from_interrupt,
  input  wire logic              instr_done,
  output logic                   irq_req,
  output logic                   irq_high,
  output logic      [15:0]       irq_vector,
  output logic      [4:0]        irq_src,
  output logic                   irq_out
);

  // Lowest set bit, with a found flag in bit 5
  function automatic logic [5:0] first_set(input logic [NUM_SRC-1:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  // Vector address of an order position
  function automatic logic [15:0] vec_of(input logic [4:0] idx);
    return VEC_BASE + (16'(idx) << VEC_STEP_LG2);
  endfunction

  // Software registers
  logic [7:0]  en0_reg, ie1_reg, ie2_reg; // Enables, global in en0 bit 7
  logic [7:0]  ip0_reg, ip1_reg, ip2_reg; // Priority selects, 1 = high
  logic [1:0]  stat_reg;                  // Sticky events
  logic [1:0]  mask_reg;                  // Event mask
  // Service tracking
  logic        act_lo_reg;                // Low routine in service
  logic        act_hi_reg;                // High routine in service
  logic        hold_reg;                  // Return seen, one more instr
  logic        ack_reg;                   // Bus answer phase
  logic        irq_req_next, irq_high_next;

  // Raw pending flags by order position
  logic [NUM_SRC-1:0] pend_w;
  always_comb begin
    pend_w = other_src_flags;
    pend_w[SRC_EXT0]    = timer_ctrl_reg[BIT_EXT0_FLG];
    pend_w[SRC_TIMER2]  = timer2_ctrl_reg[BIT_T2_FLG];
    pend_w[SRC_CNT_ARR] = counter_array_ctrl_reg[BIT_CA_OVF]
                        | (|counter_array_ctrl_reg[NUM_CC-1:0]);
    pend_w[SRC_CMP0_F]  = comp0_ctrl_reg[BIT_CMP_FALL];
    pend_w[SRC_CMP0_R]  = comp0_ctrl_reg[BIT_CMP_RISE];
    pend_w[SRC_CONV]    = converter_ctrl_reg[BIT_CONV_FLG];
    pend_w[SRC_UNUSED]  = 1'b0;       // Unused slot never requests
    pend_w[SRC_XTAL]    = crystal_valid_flag;
  end

  // Enable and priority maps in order-position layout
  wire [NUM_SRC-1:0] en_w   = {ie2_reg, ie1_reg, en0_reg[5:0]};
  wire [NUM_SRC-1:0] prio_w = {ip2_reg, ip1_reg, ip0_reg[5:0]};
  wire               glob_w = en0_reg[BIT_GLOBAL];
  wire [NUM_SRC-1:0] hi_cand = pend_w & en_w & prio_w;
  wire [NUM_SRC-1:0] lo_cand = pend_w & en_w & ~prio_w;
  wire [5:0]         hi_win  = first_set(hi_cand);
  wire [5:0]         lo_win  = first_set(lo_cand);

  // Admission: hi only when no hi active, lo only when idle
  wire hi_ok  = hi_win[5] & ~act_hi_reg;
  wire lo_ok  = lo_win[5] & ~act_hi_reg & ~act_lo_reg;
  wire gate_w = glob_w & ~hold_reg & ~long_call;
  wire [4:0] win_src = hi_ok ? hi_win[4:0] : lo_win[4:0];

  always_comb begin
    irq_req_next  = gate_w & (hi_ok | lo_ok);
    irq_high_next = hi_ok;
  end

  // Decode registered every cycle: one detect clock
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_req    <= 1'b0;
      irq_high   <= 1'b0;
      irq_src    <= 5'h00;
      irq_vector <= VEC_RESET;
    end else begin
      irq_req    <= irq_req_next;
      irq_high   <= irq_high_next;
      irq_src    <= win_src;
      irq_vector <= vec_of(win_src);
    end
  end

  // Level stack: call pushes, return pops the top level
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      act_lo_reg <= 1'b0;
      act_hi_reg <= 1'b0;
    end else if (long_call && irq_req) begin
      act_hi_reg <= act_hi_reg | irq_high;
      act_lo_reg <= act_lo_reg | ~irq_high;
    end else if (return_from_interrupt) begin
      if (act_hi_reg) begin
        act_hi_reg <= 1'b0;
      end else begin
        act_lo_reg <= 1'b0;
      end
    end
  end

  // One instruction must retire after a return
  // A retire in the return cycle is ignored; the hold still sets
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hold_reg <= 1'b0;
    end else if (return_from_interrupt) begin
      hold_reg <= 1'b1;
    end else if (instr_done) begin
      hold_reg <= 1'b0;
    end
  end

  // Bus decode; one wait state so read data can be registered
  wire        bus_req  = avs_read | avs_write;
  wire        wr_take  = avs_write & ack_reg;
  wire        lane0    = avs_byteenable[0];
  wire [7:0]  wd       = avs_writedata[7:0];
  wire        wr_en0   = wr_take & lane0 & (avs_address == ADDR_EN0);
  wire        wr_ie1   = wr_take & lane0 & (avs_address == ADDR_IE1);
  wire        wr_ie2   = wr_take & lane0 & (avs_address == ADDR_IE2);
  wire        wr_ip0   = wr_take & lane0 & (avs_address == ADDR_IP0);
  wire        wr_ip1   = wr_take & lane0 & (avs_address == ADDR_IP1);
  wire        wr_ip2   = wr_take & lane0 & (avs_address == ADDR_IP2);
  wire        wr_stat  = wr_take & lane0 & (avs_address == ADDR_STAT);
  wire        wr_mask  = wr_take & lane0 & (avs_address == ADDR_MASK);
  assign avs_waitrequest = bus_req & ~ack_reg;

  // Answer phase toggles so every access takes two edges
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
    end
  end

  // Enable and priority storage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      en0_reg <= RST_ENABLE;
      ie1_reg <= RST_ENABLE;
      ie2_reg <= RST_ENABLE;
      ip0_reg <= RST_PRIO;
      ip1_reg <= RST_PRIO;
      ip2_reg <= RST_PRIO;
    end else begin
      if (wr_en0) en0_reg <= wd;
      if (wr_ie1) ie1_reg <= wd;
      if (wr_ie2) ie2_reg <= wd;
      if (wr_ip0) ip0_reg <= wd;
      if (wr_ip1) ip1_reg <= wd;
      if (wr_ip2) ip2_reg <= wd;
    end
  end

  // Events: grant taken, and high grant over a low routine
  wire [1:0] ev_w = {long_call & irq_req & irq_high & act_lo_reg,
                     long_call & irq_req};
  wire [1:0] clr_w = wr_stat ? wd[1:0] : 2'b00;

  // Sticky status, set beats write-one clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stat_reg <= RST_EVENT;
      mask_reg <= RST_EVENT;
    end else begin
      stat_reg <= (stat_reg & ~clr_w) | ev_w;
      if (wr_mask) mask_reg <= wd[1:0];
    end
  end

  // Level interrupt from unmasked sticky events
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(((stat_reg & ~clr_w) | ev_w) & mask_reg);
    end
  end

  // Read mux; unmapped addresses read zero
  logic [31:0] rd_w;
  always_comb begin
    case (avs_address)
      ADDR_EN0:  rd_w = {24'h000000, en0_reg};
      ADDR_IE1:  rd_w = {24'h000000, ie1_reg};
      ADDR_IE2:  rd_w = {24'h000000, ie2_reg};
      ADDR_IP0:  rd_w = {24'h000000, ip0_reg};
      ADDR_IP1:  rd_w = {24'h000000, ip1_reg};
      ADDR_IP2:  rd_w = {24'h000000, ip2_reg};
      ADDR_PEND: rd_w = {10'h000, pend_w};
      ADDR_SVC:  rd_w = {19'h00000, irq_src, 4'h0, irq_req,
                         hold_reg, act_hi_reg, act_lo_reg};
      ADDR_STAT: rd_w = {30'h00000000, stat_reg};
      ADDR_MASK: rd_w = {30'h00000000, mask_reg};
      default:   rd_w = 32'h00000000;
    endcase
  end

  // Read data registered in the wait cycle, stands in answer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !ack_reg) begin
      avs_readdata <= rd_w;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  detect_one_a: assert property (
    (gate_w && (hi_ok || lo_ok)) |=> irq_req)
    else $error("request not raised one clock after detect");

  vector_map_a: assert property (
    irq_req |-> irq_vector == VEC_BASE + {8'h00, irq_src, 3'h0})
    else $error("vector not eight-byte spaced");

  ext0_vec_a: assert property (
    (irq_req && irq_src == SRC_EXT0) |-> irq_vector == 16'h0003)
    else $error("external zero vector wrong");

  hi_preempt_a: assert property (
    (act_lo_reg && !act_hi_reg && hi_win[5] && gate_w)
      |=> irq_req && irq_high)
    else $error("high request did not preempt low");

  hi_locked_a: assert property (
    act_hi_reg |-> !irq_req)
    else $error("request during high routine");

  return_from_interrupt_hold_a: assert property (
    return_from_interrupt |=> hold_reg ##1 !irq_req)
    else $error("request too soon after return");

  prio_reset_a: assert property (
    $past(rst) |-> prio_w == '0)
    else $error("priority not low after reset");

  level_win_a: assert property (
    (gate_w && hi_ok) |=> irq_high && irq_src == $past(hi_win[4:0]))
    else $error("high level did not win");

  order_win_a: assert property (
    (gate_w && !hi_win[5] && lo_ok) |=>
      !irq_high && irq_src == $past(lo_win[4:0]))
    else $error("low order arbitration wrong");

  restore_a: assert property (
    (return_from_interrupt && act_hi_reg && act_lo_reg && !long_call)
      |=> act_lo_reg && !act_hi_reg)
    else $error("level not restored on return");

  // Service gating around call, return and retire
  hold_gate_a: assert property (
    hold_reg
      |=> !irq_req)
    else $error("request offered before the retire");

  lo_wait_a: assert property (
    (act_lo_reg && !hi_win[5])
      |=> !irq_req)
    else $error("equal level request admitted in service");

  release_call_a: assert property (
    ($fell(hold_reg) && glob_w && !long_call && (hi_ok || lo_ok))
      |=> irq_req)
    else $error("request late after the retire");

  call_drop_a: assert property (
    (long_call && irq_req)
      |=> !irq_req)
    else $error("request still offered after the call");

  // Level and enable of the offered source
  level_pick_a: assert property (
    irq_req
      |-> irq_high == $past(prio_w[win_src]))
    else $error("offered level differs from its select bit");

  en_gate_a: assert property (
    irq_req
      |-> $past(en_w[win_src] && glob_w))
    else $error("disabled source offered");

  // Spot vectors at fixed addresses
  t2_vec_a: assert property (
    (irq_req && irq_src == SRC_TIMER2)
      |-> irq_vector == 16'h002B)
    else $error("timer 2 vector wrong");

  ca_vec_a: assert property (
    (irq_req && irq_src == SRC_CNT_ARR)
      |-> irq_vector == 16'h004B)
    else $error("counter array vector wrong");

  fall_vec_a: assert property (
    (irq_req && irq_src == SRC_CMP0_F)
      |-> irq_vector == 16'h0053)
    else $error("comparator fall vector wrong");

  rise_vec_a: assert property (
    (irq_req && irq_src == SRC_CMP0_R)
      |-> irq_vector == 16'h005B)
    else $error("comparator rise vector wrong");

  conv_vec_a: assert property (
    (irq_req && irq_src == SRC_CONV)
      |-> irq_vector == 16'h007B)
    else $error("conversion done vector wrong");

  xtal_vec_a: assert property (
    (irq_req && irq_src == SRC_XTAL)
      |-> irq_vector == 16'h00AB)
    else $error("crystal valid vector wrong");

  vec_range_a: assert property (
    irq_req
      |-> (irq_vector <= VEC_LAST) && (irq_src != SRC_UNUSED))
    else $error("vector outside the table");

endmodule // vtiu_top

/* File: tb/vtiu_core_model.sv */
`timescale 1ns/1ps
// Behavioural core: takes offered vectors, pulses return and retire
module vtiu_core_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        irq_req,
  input  wire logic [15:0] irq_vector,
  input  wire logic [3:0]  take_delay,
  output logic             long_call,
  output logic             return_from_interrupt,
  output logic             instr_done,
  output logic [7:0]       taken_cnt,
  output logic [15:0]      taken_vec
);
  logic [3:0] wait_cnt; // Cycles stalled on the current offer

  initial begin
    return_from_interrupt = 1'b0;
    instr_done = 1'b0;
  end

  // Stall a chosen number of cycles, then take; call cycles not modelled
  always @(posedge sys_clk) begin
    if (rst) begin
      long_call <= 1'b0;
      wait_cnt  <= 4'h0;
      taken_cnt <= 8'h00;
      taken_vec <= 16'h0000;
    end else begin
      long_call <= 1'b0;
      if (long_call && irq_req) begin // Vector taken
        taken_cnt <= taken_cnt + 8'h01;
        taken_vec <= irq_vector;
      end else if (irq_req) begin // Slow or prompt answer
        if (wait_cnt >= take_delay) begin
          long_call <= 1'b1;
          wait_cnt  <= 4'h0;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end

  // Return executes; one more instruction must retire after it
  task automatic pulse_ret();
    @(posedge sys_clk);
    return_from_interrupt <= 1'b1;
    @(posedge sys_clk);
    return_from_interrupt <= 1'b0;
  endtask

  // The single instruction after a return retires
  task automatic pulse_done();
    @(posedge sys_clk);
    instr_done <= 1'b1;
    @(posedge sys_clk);
    instr_done <= 1'b0;
  endtask
endmodule // vtiu_core_model

/* File: tb/vtiu_top_tb.sv */
`timescale 1ns/1ps
// Self-checking bench for the vectored interrupt unit
module vtiu_top_tb
  import vtiu_pkg::*;
;
  logic               sys_clk = 1'b0;
  logic               rst = 1'b1;
  logic [5:0]         avs_address = 6'h00;
  logic               avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0]        avs_writedata = 32'h0, avs_readdata;
  logic [3:0]         avs_byteenable = 4'hF;
  logic [7:0]         timer_ctrl_reg = 8'h00, timer2_ctrl_reg = 8'h00;
  logic [7:0]         counter_array_ctrl_reg = 8'h00, comp0_ctrl_reg = 8'h00;
  logic [7:0]         converter_ctrl_reg = 8'h00;
  logic               crystal_valid_flag = 1'b0;
  logic [NUM_SRC-1:0] other_src_flags = '0;
  logic               long_call, return_from_interrupt, instr_done;
  logic               irq_req, irq_high, irq_out;
  logic [15:0]        irq_vector, taken_vec;
  logic [4:0]         irq_src;
  logic [7:0]         taken_cnt, n_take = 8'h00;
  logic [3:0]         take_delay = 4'h0; // Core stall before taking
  int                 err_total = 0, n_compared = 0;
  logic [31:0]        q; // Last read data

  always #4 sys_clk = ~sys_clk;

  vtiu_top i_dut (.sys_clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .timer_ctrl_reg, .timer2_ctrl_reg, .counter_array_ctrl_reg,
    .comp0_ctrl_reg, .converter_ctrl_reg, .crystal_valid_flag,
    .other_src_flags, .long_call, .return_from_interrupt, .instr_done,
    .irq_req, .irq_high, .irq_vector, .irq_src, .irq_out);
  vtiu_core_model i_core (.sys_clk, .rst, .irq_req, .irq_vector,
    .take_delay, .long_call, .return_from_interrupt, .instr_done,
    .taken_cnt, .taken_vec);

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // A hang counts as a mismatch and closes the run
  task automatic hang();
    err_total++;
    give_verdict();
  endtask

  // One bus access; held until waitrequest is sampled low at an edge
  task automatic bus(logic wr, logic [5:0] a, logic [7:0] d);
    int i;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 50) hang();
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(logic [5:0] a, logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check("register", q[15:0], {8'h00, exp});
  endtask

  // Flag of a source by order position, at its own peripheral bit or else in other_src_flags
  task automatic set_flag(int s, logic v);
    case (s)
      0:  timer_ctrl_reg[BIT_EXT0_FLG] <= v;
      5:  timer2_ctrl_reg[BIT_T2_FLG] <= v;
      9:  counter_array_ctrl_reg[BIT_CA_OVF] <= v;
      10: comp0_ctrl_reg[BIT_CMP_FALL] <= v;
      11: comp0_ctrl_reg[BIT_CMP_RISE] <= v;
      15: converter_ctrl_reg[BIT_CONV_FLG] <= v;
      21: crystal_valid_flag <= v;
      default: other_src_flags[s] <= v;
    endcase
  endtask

  // Offered request one edge after the flag appeared
  task automatic offer(int s, logic hi);
    @(posedge sys_clk);
    #1;
    check("request", {15'h0, irq_req}, 16'h0001);
    check("vector", irq_vector, VEC_BASE + (16'(s) << VEC_STEP_LG2));
    check("source", {11'h0, irq_src}, 16'(s));
    check("level", {15'h0, irq_high}, {15'h0, hi});
  endtask

  task automatic take(int s);
    int i;
    for (i = 0; i < 60; i++) begin
      @(posedge sys_clk);
      if (taken_cnt === n_take + 8'h01) break;
    end
    if (i == 60) hang();
    n_take++;
    check("taken", taken_vec, VEC_BASE + (16'(s) << VEC_STEP_LG2));
  endtask

  task automatic hold_off(int n);
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      check("withheld", {15'h0, irq_req}, 16'h0000);
    end
  endtask

  task automatic finish_isr();
    i_core.pulse_ret();
    i_core.pulse_done();
    repeat (2) @(posedge sys_clk);
  endtask

  // Priority bits reset low; unmapped place reads zero
  task automatic sc_reset();
    rd(ADDR_IP0, RST_PRIO);
    rd(ADDR_IP1, RST_PRIO);
    rd(ADDR_IP2, RST_PRIO);
    bus(1'b1, 6'h28, 8'hFF);
    rd(6'h28, 8'h00);
    avs_byteenable <= 4'hE;
    bus(1'b1, ADDR_IP0, 8'hFF);
    avs_byteenable <= 4'hF;
    rd(ADDR_IP0, RST_PRIO);
  endtask

  // Every source alone, with varied core stalls
  task automatic sc_vectors();
    bus(1'b1, ADDR_EN0, 8'h3F);
    set_flag(1, 1'b1);
    hold_off(3); // Global enable off withholds all
    @(posedge sys_clk);
    set_flag(1, 1'b0);
    bus(1'b1, ADDR_EN0, 8'hBF);
    bus(1'b1, ADDR_IE1, 8'hFF);
    bus(1'b1, ADDR_IE2, 8'hBF);
    for (int s = 0; s < NUM_SRC; s++) begin
      if (s == 20) continue;
      take_delay <= 4'(s % 4);
      set_flag(s, 1'b1);
      offer(s, 1'b0);
      take(s);
      set_flag(s, 1'b0);
      finish_isr();
    end
    counter_array_ctrl_reg[0] <= 1'b1;
    offer(9, 1'b0);
    take(9);
    counter_array_ctrl_reg[0] <= 1'b0;
    finish_isr();
  endtask

  // Same level by order, then higher level first
  task automatic sc_order();
    take_delay <= 4'h0;
    set_flag(7, 1'b1);
    set_flag(4, 1'b1);
    offer(4, 1'b0);
    take(4);
    set_flag(4, 1'b0);
    set_flag(7, 1'b0);
    finish_isr();
    bus(1'b1, ADDR_IP1, 8'hC2);
    rd(ADDR_IP1, 8'hC2);
    set_flag(7, 1'b1);
    set_flag(4, 1'b1);
    offer(7, 1'b1);
    take(7);
    set_flag(7, 1'b0);
    i_core.pulse_ret();
    hold_off(3);
    i_core.pulse_done();
    take(4);
    set_flag(4, 1'b0);
    finish_isr();
  endtask

  // Nesting: low, high preempts, high withheld, levels restored
  task automatic sc_preempt();
    set_flag(3, 1'b1);
    take(3);
    set_flag(3, 1'b0);
    set_flag(1, 1'b1);
    hold_off(4);
    @(posedge sys_clk);
    set_flag(12, 1'b1);
    offer(12, 1'b1);
    take(12);
    set_flag(12, 1'b0);
    set_flag(13, 1'b1);
    hold_off(4);
    i_core.pulse_ret();
    hold_off(8);
    i_core.pulse_done();
    take(13);
    set_flag(13, 1'b0);
    finish_isr();
    hold_off(4);
    i_core.pulse_ret();
    i_core.pulse_done();
    take(1);
    set_flag(1, 1'b0);
    finish_isr();
  endtask

  // Sticky events, mask and level output
  task automatic sc_irq();
    #1;
    check("irq idle", {15'h0, irq_out}, 16'h0000);
    rd(ADDR_STAT, 8'h03);
    bus(1'b1, ADDR_MASK, 8'h01);
    repeat (2) @(posedge sys_clk);
    #1;
    check("irq set", {15'h0, irq_out}, 16'h0001);
    bus(1'b1, ADDR_STAT, 8'h03);
    repeat (2) @(posedge sys_clk);
    #1;
    check("irq cleared", {15'h0, irq_out}, 16'h0000);
    rd(ADDR_STAT, 8'h00);
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    sc_reset();
    sc_vectors();
    sc_order();
    sc_preempt();
    sc_irq();
    give_verdict();
  end
endmodule // vtiu_top_tb
